// *** i2c_cfg_pkg.sv ***
// shared constants for the two-wire configuration link
// assumes a 100 MHz system clock at both ends
package i2c_cfg_pkg;
  localparam logic [6:0] TARGET_ADDR = 7'h6A;
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_SAVE = 2'h1;
  localparam logic [1:0] CMD_RESTORE = 2'h2;
  localparam logic [7:0] IDENT_VALUE = 8'hA5; // arbitrary value
  localparam int CLK_MHZ = 100;
  localparam int SCL_HALF_NS = 1300;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int REG_COUNT = 256;
  localparam int NV_CYCLES_PER_WORD = 4;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
endpackage

// *** i2c_cfg_if.sv ***
// two-wire bus carrier; resolves open-drain lines from the enables
// assumes pull-ups: a line is high unless some end drives it low
`timescale 1ns/10ps
interface i2c_cfg_if;
  logic scl_oe_m;
  logic sda_oe_m;
  logic sda_oe_d;
  logic scl;
  logic serial_data_line;
  // wired-and of the open-drain drivers
  assign scl = ~scl_oe_m;
  assign serial_data_line = ~(sda_oe_m | sda_oe_d);
  modport master (output scl_oe_m, output sda_oe_m, input scl, input serial_data_line);
  modport target (output sda_oe_d, input scl, input serial_data_line);
endinterface

// *** i2c_cfg_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
// assumes one clock and active-low async reset
`timescale 1ns/10ps
module i2c_cfg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem_r[rp_r];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  // storage has no reset on purpose
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
  // pointers and fill level
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** i2c_cfg_target.sv ***
// configuration target end: command decode, register file, nv store
// assumes line levels from the carrier; own reset is power-up only
`timescale 1ns/10ps
// How it works
// R1 - answer only to address 1101010
// R2 - master sends address plus direction first
// R3 - ack drives data low, nack leaves high
// R4 - second write byte low bits give command
// R5 - third byte sets pointer, pointer autoincrements
// R6 - store each byte, ack, then increment
// R7 - reads return ident byte then registers
// R8 - master nacks last read byte, stop
// R9 - random read first sets pointer by write
// R10 - repeated start keeps freshly set pointer
// R11 - repeated start may replace stop
// R12 - command 01 saves registers to nv store
// R13 - command 10 restores registers from store
// R14 - save/restore frame is address, command, stop
// R15 - execute after stop, no ack meanwhile
// R16 - others treat bus busy during execution
// R17 - restore at power-up before acknowledging
// R18 - release line for foreign address transfers
module i2c_cfg_target #(
  parameter int NREG = i2c_cfg_pkg::REG_COUNT
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  i2c_cfg_if.target bus,
  output logic busy_out,
  output logic [7:0] last_write_data_out,
  output logic last_write_valid_out
);
  typedef enum {ST_IDLE, ST_ADDR, ST_CMD, ST_PTR, ST_WDATA, ST_RDATA, ST_ACK, ST_RACK, ST_IGNORE} st_type;
  typedef enum {NV_RESTORE, NV_SAVE, NV_IDLE} nv_type;
  logic [7:0] regs_r [NREG];
  logic [7:0] nvmem_r [NREG];
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  st_type st_r;
  st_type after_ack_r;
  nv_type nv_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic [7:0] ptr_r;
  logic [7:0] idx_r;
  logic [$clog2(i2c_cfg_pkg::NV_CYCLES_PER_WORD)-1:0] nvc_r;
  logic [1:0] pend_r;
  logic first_rd_r;
  logic drive_r;
  logic ack_ok;
  //////////////////////////////////////////////////////////////
  // two-stage synchronisers, then edge and condition detect
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], bus.scl};
      sda_s_r <= {sda_s_r[0], bus.serial_data_line};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end
  assign scl_rise = scl_s_r[1] & ~scl_d_r;
  assign scl_fall = ~scl_s_r[1] & scl_d_r;
  assign start_c = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1]; // R11
  assign stop_c = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];
  assign busy_out = (nv_r != NV_IDLE); // R16
  assign bus.sda_oe_d = drive_r; // R3
  // address acks withheld while the nv store runs
  assign ack_ok = (sh_r[7:1] == i2c_cfg_pkg::TARGET_ADDR) && !busy_out; // R1 R15 R17
  //////////////////////////////////////////////////////////////
  // nv store engine: power-up restore, then on-demand commands
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nv_r <= NV_RESTORE; // R17
      idx_r <= 8'h00;
      nvc_r <= '0;
    end else if (nv_r == NV_IDLE) begin
      idx_r <= 8'h00;
      if (stop_c && pend_r == i2c_cfg_pkg::CMD_SAVE) nv_r <= NV_SAVE; // R12 R15
      if (stop_c && pend_r == i2c_cfg_pkg::CMD_RESTORE) nv_r <= NV_RESTORE; // R13 R15
    end else begin
      nvc_r <= nvc_r + 1'b1;
      if (&nvc_r) begin
        idx_r <= idx_r + 1'b1;
        if (idx_r == 8'(NREG - 1)) nv_r <= NV_IDLE;
      end
    end
  end
  // eeprom array, written only by a save
  always_ff @(posedge clk_sys_in) begin
    if (nv_r == NV_SAVE && &nvc_r) nvmem_r[idx_r] <= regs_r[idx_r]; // R12
  end
  // register array: bus writes and restores
  // a restore owns the array; the bus is told busy meanwhile
  always_ff @(posedge clk_sys_in) begin
    if (nv_r == NV_RESTORE && &nvc_r) begin
      regs_r[idx_r] <= nvmem_r[idx_r]; // R13
    end else if (st_r == ST_WDATA && bit_r == 4'h8 && scl_fall) begin
      regs_r[ptr_r] <= sh_r; // R6
    end
  end
  //////////////////////////////////////////////////////////////
  // bit-level protocol engine
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      ptr_r <= 8'h00;
      pend_r <= 2'h3;
      first_rd_r <= 1'b0;
      drive_r <= 1'b0;
      last_write_data_out <= 8'h00;
      last_write_valid_out <= 1'b0;
    end else begin
      last_write_valid_out <= 1'b0;
      if (stop_c) begin
        st_r <= ST_IDLE;
        drive_r <= 1'b0;
        pend_r <= 2'h3;
      end else if (start_c) begin
        st_r <= ST_ADDR; // R2
        bit_r <= 4'h0;
        drive_r <= 1'b0;
      end else if (st_r == ST_ACK || st_r == ST_RACK) begin
        if (scl_fall) begin
          if (st_r == ST_RACK) begin
            // sample of master ack taken at previous rise
            if (sh_r[0]) begin
              st_r <= ST_IGNORE; // R8
              drive_r <= 1'b0;
            end else begin
              st_r <= ST_RDATA;
              drive_r <= ~regs_r[ptr_r][7]; // R7
              sh_r <= regs_r[ptr_r];
              bit_r <= 4'h1;
            end
          end else if (drive_r) begin
            drive_r <= 1'b0;
            st_r <= after_ack_r;
            bit_r <= 4'h0;
            if (after_ack_r == ST_RDATA) begin
              sh_r <= i2c_cfg_pkg::IDENT_VALUE;
              drive_r <= ~i2c_cfg_pkg::IDENT_VALUE[7]; // R7
              bit_r <= 4'h1;
              first_rd_r <= 1'b1;
            end
          end
        end else if (scl_rise && st_r == ST_RACK) begin
          sh_r[0] <= sda_s_r[1];
        end
      end else if (st_r == ST_RDATA) begin
        if (scl_fall) begin
          if (bit_r == 4'h8) begin
            drive_r <= 1'b0; // release for master ack
            st_r <= ST_RACK;
            if (!first_rd_r) ptr_r <= ptr_r + 1'b1; // R5
            first_rd_r <= 1'b0;
          end else begin
            drive_r <= ~sh_r[6];
            sh_r <= {sh_r[6:0], 1'b0};
            bit_r <= bit_r + 1'b1;
          end
        end
      end else if (st_r != ST_IDLE && st_r != ST_IGNORE) begin
        if (scl_rise && bit_r != 4'h8) begin
          sh_r <= {sh_r[6:0], sda_s_r[1]};
          bit_r <= bit_r + 1'b1;
        end else if (scl_fall && bit_r == 4'h8) begin
          st_r <= ST_ACK;
          drive_r <= 1'b1; // R3
          case (st_r)
            ST_ADDR: begin
              if (!ack_ok) begin
                drive_r <= 1'b0; // R18
                st_r <= ST_IGNORE;
              end else if (sh_r[0] == i2c_cfg_pkg::RW_READ) begin
                after_ack_r <= ST_RDATA; // R10
              end else begin
                after_ack_r <= ST_CMD;
              end
            end
            ST_CMD: begin
              pend_r <= sh_r[1:0]; // R4 R14
              after_ack_r <= (sh_r[1:0] == i2c_cfg_pkg::CMD_WRITE) ? ST_PTR : ST_IGNORE;
            end
            ST_PTR: begin
              ptr_r <= sh_r; // R5 R9
              after_ack_r <= ST_WDATA;
            end
            default: begin
              ptr_r <= ptr_r + 1'b1; // R6
              last_write_data_out <= sh_r;
              last_write_valid_out <= 1'b1;
              after_ack_r <= ST_WDATA;
            end
          endcase
        end
      end
    end
  end
endmodule

// *** i2c_cfg_master.sv ***
// bus master end: runs queued byte requests on the two-wire link
// assumes user queues requests; scl made by divider from clk_sys_in
`timescale 1ns/10ps
module i2c_cfg_master (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  i2c_cfg_if.master bus,
  input wire logic [10:0] req_data_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic ack_ok_out,
  output logic idle_out
);
  // request word: [10]=start before, [9]=stop after, [8]=read, [7:0]=byte
  typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} mst_type;
  mst_type st_r;
  logic [10:0] q_data;
  logic q_valid;
  logic q_pop;
  localparam int DW = $clog2(i2c_cfg_pkg::SCL_HALF_CYC + 1);
  logic [DW-1:0] div_r;
  logic tick;
  logic phase_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic rd_r;
  logic stop_r;
  logic [1:0] sda_s_r;
  // request buffer; back-pressure reaches the user
  i2c_cfg_fifo #(.WIDTH(11), .DEPTH(16)) i2c_cfg_fifo_i (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .in_data_in(req_data_in),
    .in_valid_in(req_valid_in),
    .in_ready_out(req_ready_out),
    .out_data_out(q_data),
    .out_valid_out(q_valid),
    .out_ready_in(q_pop)
  );
  assign tick = (div_r == '0);
  assign q_pop = (st_r == M_IDLE || (st_r == M_ACK && tick && phase_r && !stop_r)) && q_valid && tick;
  assign idle_out = (st_r == M_IDLE) && !q_valid;
  // half-period divider for scl
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_r <= '0;
    end else begin
      div_r <= tick ? DW'(i2c_cfg_pkg::SCL_HALF_CYC - 1) : div_r - 1'b1;
    end
  end
  // synchroniser for sampled data line
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) sda_s_r <= 2'h3;
    else sda_s_r <= {sda_s_r[0], bus.serial_data_line};
  end
  //////////////////////////////////////////////////////////////
  // phase 0: scl low, drive data; phase 1: scl high, sample
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= M_IDLE;
      phase_r <= 1'b0;
      bus.scl_oe_m <= 1'b0;
      bus.sda_oe_m <= 1'b0;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      rd_r <= 1'b0;
      stop_r <= 1'b0;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
      ack_ok_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      if (tick) begin
        case (st_r)
          M_IDLE, M_ACK: begin
            if (st_r == M_ACK && !phase_r) begin
              bus.scl_oe_m <= 1'b0;
              phase_r <= 1'b1;
            end else if (st_r == M_ACK && stop_r) begin
              if (!rd_r) ack_ok_out <= ~sda_s_r[1];
              bus.scl_oe_m <= 1'b1;
              bus.sda_oe_m <= 1'b1;
              phase_r <= 1'b0;
              st_r <= M_STOP;
            end else begin
              if (st_r == M_ACK) begin
                if (!rd_r) ack_ok_out <= ~sda_s_r[1];
                bus.scl_oe_m <= 1'b1;
                bus.sda_oe_m <= 1'b0;
              end
              if (q_valid) begin
                sh_r <= q_data[7:0];
                rd_r <= q_data[8];
                stop_r <= q_data[9];
                bit_r <= 4'h0;
                phase_r <= 1'b0;
                st_r <= q_data[10] ? M_START : M_BIT;
              end else if (st_r == M_ACK) begin
                st_r <= M_STOP;
                bus.sda_oe_m <= 1'b1;
                phase_r <= 1'b0;
              end
            end
          end
          M_START: begin
            // release both, then pull data low while clock high
            if (!phase_r) begin
              bus.sda_oe_m <= 1'b0;
              bus.scl_oe_m <= 1'b0;
              phase_r <= 1'b1;
            end else begin
              bus.sda_oe_m <= 1'b1; // start or repeated start
              phase_r <= 1'b0;
              st_r <= M_BIT;
            end
          end
          M_BIT: begin
            if (!phase_r) begin
              bus.scl_oe_m <= 1'b1;
              if (bit_r == 4'h8) begin
                // master ack: nack the last read byte
                bus.sda_oe_m <= rd_r & ~stop_r;
                st_r <= M_ACK;
              end else begin
                bus.sda_oe_m <= rd_r ? 1'b0 : ~sh_r[7];
                phase_r <= 1'b1;
              end
            end else begin
              bus.scl_oe_m <= 1'b0;
              sh_r <= {sh_r[6:0], sda_s_r[1]};
              bit_r <= bit_r + 1'b1;
              phase_r <= 1'b0;
              if (bit_r == 4'h7 && rd_r) begin
                rd_data_out <= {sh_r[6:0], sda_s_r[1]};
                rd_valid_out <= 1'b1;
              end
            end
          end
          default: begin
            // stop: clock high, then release data
            if (!phase_r) begin
              bus.scl_oe_m <= 1'b0;
              phase_r <= 1'b1;
            end else begin
              bus.sda_oe_m <= 1'b0;
              phase_r <= 1'b0;
              st_r <= M_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule

// *** i2c_cfg_link_sva.sv ***
// checker for the two-wire link between the master and target ends
// assumes it watches the resolved lines and enables of the carrier
`timescale 1ns/10ps
module i2c_cfg_link_sva (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic sda_oe_d,
  input wire logic scl,
  input wire logic serial_data_line
);
  logic scl_r, sda_r, rd_r, ack_r, nack_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic [7:0] sh_r;
  logic rise, start;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  assign rise = scl & ~scl_r;
  assign start = scl & scl_r & sda_r & ~serial_data_line;
  // line history, idle level after reset
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl;
      sda_r <= serial_data_line;
    end
  end
  // bit and byte position, restarted by every start so repeated starts count too
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      sh_r <= 8'h00;
      rd_r <= 1'b0;
      ack_r <= 1'b0;
      nack_r <= 1'b0;
    end else if (start) begin
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      ack_r <= 1'b0;
      nack_r <= 1'b0;
    end else if (rise && bit_r != 4'h8) begin
      sh_r <= {sh_r[6:0], serial_data_line};
      bit_r <= bit_r + 4'h1;
    end else if (rise) begin
      bit_r <= 4'h0;
      byte_r <= (byte_r == 2'h3) ? byte_r : byte_r + 2'h1;
      if (byte_r == 2'h0) begin
        rd_r <= sh_r[0];
        ack_r <= ~serial_data_line;
      end else if (rd_r && serial_data_line) begin
        nack_r <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence slot_s;
    rise && bit_r == 4'h8;
  endsequence
  sequence addr_slot_s;
    slot_s ##0 byte_r == 2'h0;
  endsequence
  addr_quiet_a: assert property (rise && byte_r == 2'h0 && bit_r != 4'h8 |-> !sda_oe_d)
    else $error("target drove during address bits");
  foreign_nack_a: assert property (addr_slot_s ##0 sh_r[7:1] != i2c_cfg_pkg::TARGET_ADDR |-> !sda_oe_d)
    else $error("target acked a foreign address");
  write_ack_a: assert property (slot_s ##0 (byte_r != 2'h0 && !rd_r && ack_r) |-> sda_oe_d)
    else $error("write byte not acked");
  ident_first_a: assert property (slot_s ##0 (byte_r == 2'h1 && rd_r && ack_r) |-> sh_r == i2c_cfg_pkg::IDENT_VALUE)
    else $error("first read byte not ident");
  master_slot_a: assert property (slot_s ##0 (byte_r != 2'h0 && rd_r) |-> !sda_oe_d)
    else $error("target drove the master ack slot");
  nack_release_a: assert property (nack_r |-> !sda_oe_d)
    else $error("target drove after master nack");
  oe_stable_a: assert property (scl && scl_r |-> $stable(sda_oe_d))
    else $error("target data changed while clock high");
  start_master_a: assert property (start |-> sda_oe_m && !sda_oe_d)
    else $error("start not made by master");
endmodule

// *** i2c_config_eeprom_cmd_bench.sv ***
// bench: master and target ends joined by the two-wire carrier
// assumes package, carrier, fifo, both ends and checker compile first
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module i2c_config_eeprom_cmd_bench;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [10:0] req_data = 11'h000;
  logic req_valid = 1'b0;
  logic req_ready, rd_valid, ack_ok, idle, busy, wr_valid;
  logic [7:0] rd_data, wr_data;
  logic [7:0] rdq[$];
  int err_count = 0;
  int n_checks = 0;
  int wr_count = 0;
  bit full_seen;
  i2c_cfg_if link ();
  i2c_cfg_master i2c_cfg_master_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus(link),
    .req_data_in(req_data), .req_valid_in(req_valid), .req_ready_out(req_ready),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .ack_ok_out(ack_ok), .idle_out(idle));
  i2c_cfg_target i2c_cfg_target_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus(link),
    .busy_out(busy), .last_write_data_out(wr_data), .last_write_valid_out(wr_valid));
  i2c_cfg_link_sva i2c_cfg_link_sva_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .scl_oe_m(link.scl_oe_m), .sda_oe_m(link.sda_oe_m), .sda_oe_d(link.sda_oe_d),
    .scl(link.scl), .serial_data_line(link.serial_data_line));
  always #5 clk_sys_in = ~clk_sys_in;
  // collect returned bytes and completed register writes
  always @(posedge clk_sys_in) begin
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (wr_valid === 1'b1) wr_count++;
  end
  ////////////////////////////////////////////////////////////////////////////
  // words are {start, stop, read, byte}; valid stays up across a frame
  task automatic frame(input logic [10:0] w[$]);
    foreach (w[i]) begin
      @(negedge clk_sys_in);
      req_data = w[i];
      req_valid = 1'b1;
      while (req_ready !== 1'b1) begin
        full_seen = 1'b1;
        @(negedge clk_sys_in);
      end
      @(posedge clk_sys_in);
    end
    @(negedge clk_sys_in);
    req_valid = 1'b0;
    // the eighteen-byte burst alone needs a little over 45k cycles
    repeat (45000) if (idle !== 1'b1) @(negedge clk_sys_in);
  endtask
  // save or restore frame; the store only starts after the stop
  task automatic nv_cmd(input logic [7:0] code);
    frame('{11'h4D4, {3'b010, code}});
    `CHK("nv cmd ack", 1'b1, ack_ok)
    repeat (20) if (busy !== 1'b1) @(negedge clk_sys_in);
    `CHK("busy after cmd", 1'b1, busy)
    // bench keeps the link quiet while the store runs
    repeat (3000) if (busy !== 1'b0) @(negedge clk_sys_in);
    `CHK("busy cleared", 1'b0, busy)
  endtask
  // power-up restore keeps the target busy before it answers
  task automatic power_up();
    @(negedge clk_sys_in);
    `CHK("busy at release", 1'b1, busy)
    repeat (3000) if (busy !== 1'b0) @(negedge clk_sys_in);
    `CHK("restore done", 1'b0, busy)
  endtask
  // burst longer than the queue, so the slow link makes it refuse
  task automatic long_write();
    logic [10:0] w[$];
    w = '{11'h4D4, 11'h000, 11'h020};
    for (int i = 0; i < 15; i++) w.push_back({3'b000, 8'h30 + 8'(i)});
    w[$] = w[$] | 11'h200;
    full_seen = 1'b0;
    wr_count = 0;
    frame(w);
    `CHK("queue refused", 1'b1, full_seen)
    `CHK("burst ack", 1'b1, ack_ok)
    `CHK("last data", 8'h3E, wr_data)
    `CHK("write count", 15, wr_count)
  endtask
  // save, overwrite one register, then restore the saved value
  task automatic save_restore();
    nv_cmd(8'h01);
    frame('{11'h4D4, 11'h000, 11'h020, 11'h2FF});
    `CHK("overwrite", 8'hFF, wr_data)
    nv_cmd(8'h02);
  endtask
  // pointer frame, repeated start, then ident and two registers
  task automatic read_back();
    rdq = {};
    frame('{11'h4D4, 11'h000, 11'h020, 11'h4D5, 11'h100, 11'h100, 11'h300});
    `CHK("read count", 3, rdq.size())
    `CHK("ident", i2c_cfg_pkg::IDENT_VALUE, rdq[0])
    `CHK("reg 20", 8'h30, rdq[1])
    `CHK("reg 21", 8'h31, rdq[2])
  endtask
  // a foreign address is left alone and nothing is stored
  task automatic foreign();
    wr_count = 0;
    frame('{11'h4A0, 11'h000, 11'h255});
    `CHK("foreign ack", 1'b0, ack_ok)
    `CHK("foreign writes", 0, wr_count)
  endtask
  task automatic complete_run();
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog sized just above the roughly 96k cycles the tests take
  initial begin
    fork
      begin
        repeat (99000) @(posedge clk_sys_in);
        err_count++;
        complete_run();
      end
    join_none
    repeat (8) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rstn_in = 1'b1;
    power_up();
    long_write();
    save_restore();
    read_back();
    foreign();
    complete_run();
  end
endmodule
